// >>> vsc_pkg.sv
package vsc_pkg;

  // ==========================================================================
  // Register indexes at the data port
  localparam logic [4:0] IDX_RESET   = 5'h00;
  localparam logic [4:0] IDX_CLOCK   = 5'h01;
  localparam logic [4:0] IDX_WMASK   = 5'h02;
  localparam logic [4:0] IDX_FONT    = 5'h03;
  localparam logic [4:0] IDX_MEMMODE = 5'h04;

  // ==========================================================================
  // Writable bits; all others are reserved and read as zero
  localparam logic [7:0] RST_MASK   = 8'h03;
  localparam logic [7:0] CLK_MASK   = 8'h3D;
  localparam logic [7:0] WMASK_MASK = 8'hFF;
  localparam logic [7:0] FONT_MASK  = 8'h3F;
  localparam logic [7:0] MM_MASK    = 8'h0E;
  localparam logic [7:0] STD_MASK   = 8'h0F;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] RST_CTRL_INIT = 2'h3;
  localparam logic [7:0] REG_INIT      = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int RST_ASYNC  = 0;
  localparam int RST_SYNC   = 1;
  localparam int CM_CHAR8   = 0;
  localparam int CM_LOAD16  = 2;
  localparam int CM_DOTDIV  = 3;
  localparam int CM_LOAD32  = 4;
  localparam int CM_FULLBW  = 5;
  localparam int MM_EXTSIZE = 1;
  localparam int MM_SEQ     = 2;
  localparam int MM_CHAIN4  = 3;
  localparam int ATTR_FONT  = 3;

  // ==========================================================================
  // Timing and encodings
  localparam logic [3:0] LAST_DOT_9  = 4'h8;
  localparam logic [3:0] LAST_DOT_8  = 4'h7;
  localparam logic [1:0] LOAD_LAST32 = 2'h3;
  localparam logic [1:0] WIDTH_8     = 2'h0;
  localparam logic [1:0] WIDTH_16    = 2'h1;
  localparam logic [1:0] WIDTH_32    = 2'h2;
  localparam logic [2:0] WMODE_1     = 3'h1;
  localparam logic [1:0] WMODE_EXT   = 2'h2;
  localparam logic [1:0] PLANE_FONT  = 2'h2;
  localparam logic [1:0] PLANE_WIDE  = 2'h3;
  localparam int         HOST_AW     = 22;
  localparam int         STD_AW      = 16;

  // ==========================================================================
  // Whole state of the block
  typedef struct packed {
    logic [4:0]         idx;
    logic [1:0]         rst_ctrl;
    logic [7:0]         clk_mode;
    logic [7:0]         wmask;
    logic [7:0]         font_sel;
    logic [7:0]         mem_mode;
    logic               dot_ph;
    logic [3:0]         dot_cnt;
    logic [1:0]         load_cnt;
    logic [7:0]         rdata;
    logic [15:0]        font_addr;
    logic               intensity;
    logic [3:0]         host_planes;
    logic [HOST_AW-1:0] host_addr;
  } vsc_state_t;

endpackage : vsc_pkg

// >>> vsc_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Sync reset bit zero halts all refresh
// - Async reset bit zero halts, clears font select
// - Run only when both reset bits one
// - Full bandwidth stops screen refresh only
// - Refresh override input forces screen refresh off
// - Load bits set shifter load rate, width
// - Dot clock bit divides master clock by two
// - Character clock nine or eight dots wide
// - Extended mask gates write mode 1 pixels
// - Extended mask gates write modes 4, 5
// - Mask also protects block transfer writes
// - Standard mode: low bits enable planes 3:0
// - Secondary font set maps to offsets
// - Primary font set uses same mapping
// - Attribute bit 3 picks font when differing and extended size is on
// - Text planes: code, attribute, font, wide
// - Index port selects register at data port
// - Chain-4 takes plane from address bits
// - Odd/even splits planes by address parity
// - Extended size off limits memory to 64K
module vsc_sequencer (
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire logic                       io_wr_i,
  input  wire logic                       io_rd_i,
  input  wire logic                       io_data_sel_i,
  input  wire logic [7:0]                 io_wdata_i,
  output logic      [7:0]                 io_rdata_o,
  input  wire logic                       graphics_ext_refresh_override_i,
  input  wire logic                       ext_write_en_i,
  input  wire logic                       wm1_ext_i,
  input  wire logic [2:0]                 graphics_write_mode_i,
  input  wire logic [7:0]                 attr_byte_i,
  input  wire logic [7:0]                 char_code_i,
  input  wire logic [4:0]                 char_row_i,
  input  wire logic                       wide_font_i,
  input  wire logic [1:0]                 text_fetch_kind_i,
  input  wire logic [vsc_pkg::HOST_AW-1:0] host_addr_i,
  output logic                            seq_run_o,
  output logic                            mem_refresh_en_o,
  output logic                            sync_en_o,
  output logic                            screen_refresh_en_o,
  output logic                            dot_clk_en_o,
  output logic                            char_clk_en_o,
  output logic                            shifter_load_o,
  output logic      [1:0]                 shift_width_o,
  output logic      [3:0]                 plane_we_o,
  output logic      [7:0]                 pixel_we_o,
  output logic      [7:0]                 blt_pixel_we_o,
  output logic                            dual_font_o,
  output logic      [15:0]                font_addr_o,
  output logic      [1:0]                 font_plane_o,
  output logic      [1:0]                 text_plane_o,
  output logic                            intensity_o,
  output logic      [3:0]                 host_plane_en_o,
  output logic      [vsc_pkg::HOST_AW-1:0] host_mem_addr_o
);

  // ==========================================================================
  // Font slot: 8K-granular offset index of a three-bit map set
  function automatic logic [2:0] font_slot(input logic [2:0] set);
    font_slot = {set[1], set[0], set[2]};
  endfunction : font_slot

  vsc_pkg::vsc_state_t s_r;
  vsc_pkg::vsc_state_t s_nxt;

  logic       run;
  logic       dot_en;
  logic       char_en;
  logic [3:0] last_dot;
  logic [2:0] pri_set;
  logic [2:0] sec_set;
  logic       dual;
  logic [7:0] reg_rd;
  logic       wm_gated;

  // ==========================================================================
  // Sequencer run state and refresh enables
  assign run                 = &s_r.rst_ctrl;
  assign seq_run_o           = run;
  assign mem_refresh_en_o    = run;
  assign sync_en_o           = run;
  assign screen_refresh_en_o = run & ~s_r.clk_mode[vsc_pkg::CM_FULLBW]
                               & ~graphics_ext_refresh_override_i;

  // Dot and character clock strobes
  assign dot_en = run & (~s_r.clk_mode[vsc_pkg::CM_DOTDIV] | s_r.dot_ph);
  assign last_dot = s_r.clk_mode[vsc_pkg::CM_CHAR8] ? vsc_pkg::LAST_DOT_8
                                                    : vsc_pkg::LAST_DOT_9;
  assign char_en       = dot_en & (s_r.dot_cnt == last_dot);
  assign dot_clk_en_o  = dot_en;
  assign char_clk_en_o = char_en;

  // Shifter load rate and memory data width
  always_comb begin
    if (s_r.clk_mode[vsc_pkg::CM_LOAD32]) begin
      shifter_load_o = char_en & (s_r.load_cnt == vsc_pkg::LOAD_LAST32);
      shift_width_o  = vsc_pkg::WIDTH_32;
    end else if (s_r.clk_mode[vsc_pkg::CM_LOAD16]) begin
      shifter_load_o = char_en & s_r.load_cnt[0];
      shift_width_o  = vsc_pkg::WIDTH_16;
    end else begin
      shifter_load_o = char_en;
      shift_width_o  = vsc_pkg::WIDTH_8;
    end
  end

  // ==========================================================================
  // Write enables for planes, pixels and the block transfer engine
  assign wm_gated = ((graphics_write_mode_i == vsc_pkg::WMODE_1) & wm1_ext_i)
                    | (graphics_write_mode_i[2:1] == vsc_pkg::WMODE_EXT);
  assign pixel_we_o = (ext_write_en_i & wm_gated) ? s_r.wmask : 8'hFF;
  assign blt_pixel_we_o = s_r.wmask;
  assign plane_we_o = (~ext_write_en_i & ~graphics_write_mode_i[2])
                      ? s_r.wmask[3:0] : 4'h0;

  // ==========================================================================
  // Font selection and text plane use
  assign pri_set = {s_r.font_sel[4], s_r.font_sel[1], s_r.font_sel[0]};
  assign sec_set = {s_r.font_sel[5], s_r.font_sel[3], s_r.font_sel[2]};
  assign dual    = s_r.mem_mode[vsc_pkg::MM_EXTSIZE] & (pri_set != sec_set);
  assign dual_font_o  = dual;
  assign font_addr_o  = s_r.font_addr;
  assign intensity_o  = s_r.intensity;
  assign font_plane_o = wide_font_i ? vsc_pkg::PLANE_WIDE : vsc_pkg::PLANE_FONT;
  assign text_plane_o = text_fetch_kind_i;
  assign host_plane_en_o = s_r.host_planes;
  assign host_mem_addr_o = s_r.host_addr;
  assign io_rdata_o      = s_r.rdata;

  // ==========================================================================
  // Register read mux, reserved bits zero
  always_comb begin
    reg_rd = 8'h00;
    if (s_r.idx == vsc_pkg::IDX_RESET) begin
      reg_rd = {6'h00, s_r.rst_ctrl};
    end else if (s_r.idx == vsc_pkg::IDX_CLOCK) begin
      reg_rd = s_r.clk_mode;
    end else if (s_r.idx == vsc_pkg::IDX_WMASK) begin
      reg_rd = ext_write_en_i ? s_r.wmask : (s_r.wmask & vsc_pkg::STD_MASK);
    end else if (s_r.idx == vsc_pkg::IDX_FONT) begin
      reg_rd = s_r.font_sel;
    end else if (s_r.idx == vsc_pkg::IDX_MEMMODE) begin
      reg_rd = s_r.mem_mode;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    // Host register access through index and data ports
    if (io_wr_i & ~io_data_sel_i) begin
      s_nxt.idx = io_wdata_i[4:0];
    end else if (io_wr_i) begin
      if (s_r.idx == vsc_pkg::IDX_RESET) begin
        s_nxt.rst_ctrl = io_wdata_i[1:0];
      end else if (s_r.idx == vsc_pkg::IDX_CLOCK) begin
        s_nxt.clk_mode = io_wdata_i & vsc_pkg::CLK_MASK;
      end else if (s_r.idx == vsc_pkg::IDX_WMASK) begin
        s_nxt.wmask = io_wdata_i & vsc_pkg::WMASK_MASK;
      end else if (s_r.idx == vsc_pkg::IDX_FONT) begin
        s_nxt.font_sel = io_wdata_i & vsc_pkg::FONT_MASK;
      end else if (s_r.idx == vsc_pkg::IDX_MEMMODE) begin
        s_nxt.mem_mode = io_wdata_i & vsc_pkg::MM_MASK;
      end
    end
    // Async reset bit low keeps the font select cleared
    if (~s_nxt.rst_ctrl[vsc_pkg::RST_ASYNC]) begin
      s_nxt.font_sel = vsc_pkg::REG_INIT;
    end
    // Read data captured one cycle after the strobe
    if (io_rd_i) begin
      s_nxt.rdata = io_data_sel_i ? reg_rd : {3'h0, s_r.idx};
    end
    // Sequencer counters, cleared while halted
    if (~run) begin
      s_nxt.dot_ph   = 1'b0;
      s_nxt.dot_cnt  = 4'h0;
      s_nxt.load_cnt = 2'h0;
    end else begin
      s_nxt.dot_ph = ~s_r.dot_ph;
      if (char_en) begin
        s_nxt.dot_cnt  = 4'h0;
        s_nxt.load_cnt = s_r.load_cnt + 2'h1;
      end else if (dot_en) begin
        s_nxt.dot_cnt = s_r.dot_cnt + 4'h1;
      end
    end
    // Font address: set in top bits, code, then row
    s_nxt.font_addr = {(dual & attr_byte_i[vsc_pkg::ATTR_FONT]) ? font_slot(sec_set)
                                                                : font_slot(pri_set),
                       char_code_i, char_row_i};
    s_nxt.intensity = dual ? 1'b0 : attr_byte_i[vsc_pkg::ATTR_FONT];
    // Host address to plane and memory address
    if (s_r.mem_mode[vsc_pkg::MM_CHAIN4]) begin
      s_nxt.host_planes = 4'h1 << host_addr_i[1:0];
      s_nxt.host_addr   = host_addr_i >> 2;
    end else if (~s_r.mem_mode[vsc_pkg::MM_SEQ]) begin
      s_nxt.host_planes = (host_addr_i[0] ? 4'hA : 4'h5) & s_r.wmask[3:0];
      s_nxt.host_addr   = host_addr_i >> 1;
    end else begin
      s_nxt.host_planes = s_r.wmask[3:0];
      s_nxt.host_addr   = host_addr_i;
    end
    if (~s_r.mem_mode[vsc_pkg::MM_EXTSIZE]) begin
      s_nxt.host_addr[vsc_pkg::HOST_AW-1:vsc_pkg::STD_AW] = '0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r          <= '0;
      s_r.rst_ctrl <= vsc_pkg::RST_CTRL_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  chk_halt_refresh: assert property (
    !s_r.rst_ctrl[vsc_pkg::RST_SYNC] |-> !mem_refresh_en_o && !screen_refresh_en_o
                                         && !dot_clk_en_o)
    else $error("refresh active while sequencer halted");

  chk_async_font_clear: assert property (
    io_wr_i && io_data_sel_i && s_r.idx == vsc_pkg::IDX_RESET && !io_wdata_i[0]
    |=> s_r.font_sel == 8'h00 && !seq_run_o)
    else $error("font select not cleared by async reset bit");

  chk_run_by_write: assert property (
    $changed(seq_run_o) |-> $past(io_wr_i && io_data_sel_i
                                  && s_r.idx == vsc_pkg::IDX_RESET))
    else $error("run state changed without reset register write");

  chk_fullbw_refresh: assert property (
    s_r.clk_mode[vsc_pkg::CM_FULLBW] |-> !screen_refresh_en_o
                                         && mem_refresh_en_o == seq_run_o
                                         && sync_en_o == seq_run_o)
    else $error("full bandwidth handling wrong");

  chk_override_off: assert property (
    graphics_ext_refresh_override_i |-> !screen_refresh_en_o)
    else $error("screen refresh on under override");

  chk_load_on_char: assert property (
    shifter_load_o && s_r.clk_mode[vsc_pkg::CM_LOAD32] |-> char_clk_en_o
                                                        && s_r.load_cnt == 2'h3)
    else $error("shifter load not on fourth character clock");

  chk_dot_halved: assert property (
    (dot_clk_en_o && s_r.clk_mode[vsc_pkg::CM_DOTDIV]
     ##1 seq_run_o && s_r.clk_mode[vsc_pkg::CM_DOTDIV]) |-> !dot_clk_en_o)
    else $error("divided dot clock ran on consecutive cycles");

  chk_char_width: assert property (
    char_clk_en_o |-> s_r.dot_cnt == (s_r.clk_mode[vsc_pkg::CM_CHAR8] ? 4'h7 : 4'h8))
    else $error("character clock width wrong");

  chk_chain4_plane: assert property (
    s_r.mem_mode[vsc_pkg::MM_CHAIN4] |=> host_plane_en_o == (4'h1 << $past(host_addr_i[1:0])))
    else $error("chain-4 plane select wrong");

  chk_std_size: assert property (
    !s_r.mem_mode[vsc_pkg::MM_EXTSIZE] |=> host_mem_addr_o[21:16] == 6'h00)
    else $error("address beyond 64K with extended size off");

  chk_font_slot: assert property (
    !dual |=> font_addr_o[15:13] == $past({pri_set[1], pri_set[0], pri_set[2]}))
    else $error("primary font offset wrong");

  chk_font_held: assert property (
    !s_r.rst_ctrl[vsc_pkg::RST_ASYNC] |-> s_r.font_sel == 8'h00 && !seq_run_o)
    else $error("font select not held clear while async bit low");

  chk_halt_strobes: assert property (
    !seq_run_o |-> !dot_clk_en_o && !char_clk_en_o && !shifter_load_o)
    else $error("timing strobe while sequencer halted");

  chk_pixel_wm1: assert property (
    ext_write_en_i && wm1_ext_i && graphics_write_mode_i == 3'h1 |-> pixel_we_o == s_r.wmask)
    else $error("write mode 1 pixel mask not applied");

  chk_pixel_ext: assert property (
    ext_write_en_i && graphics_write_mode_i[2:1] == 2'h2 |-> pixel_we_o == s_r.wmask)
    else $error("extended write mode pixel mask not applied");

  chk_plane_mask: assert property (
    !ext_write_en_i && !graphics_write_mode_i[2] |-> plane_we_o == s_r.wmask[3:0])
    else $error("plane enables do not follow mask");

  chk_plane_off: assert property (
    ext_write_en_i || graphics_write_mode_i[2] |-> plane_we_o == 4'h0)
    else $error("plane enables active outside standard modes");

  chk_sec_font: assert property (
    dual_font_o && attr_byte_i[vsc_pkg::ATTR_FONT]
    |=> font_addr_o[15:13] == $past({sec_set[1], sec_set[0], sec_set[2]}))
    else $error("secondary font offset wrong");

  chk_font_code_row: assert property (
    1'b1 |=> font_addr_o[12:0] == $past({char_code_i, char_row_i}))
    else $error("font address code or row wrong");

  chk_dual_enable: assert property (
    !s_r.mem_mode[vsc_pkg::MM_EXTSIZE] |-> !dual_font_o)
    else $error("dual font active with extended memory off");

  chk_dual_intensity: assert property (
    dual_font_o |=> !intensity_o)
    else $error("intensity driven while attribute bit picks font");

  chk_font_plane: assert property (
    font_plane_o == (wide_font_i ? 2'h3 : 2'h2))
    else $error("font fetch plane wrong");

  chk_index_read: assert property (
    io_rd_i && !io_data_sel_i |=> io_rdata_o == {3'h0, $past(s_r.idx)})
    else $error("index port read wrong");

  chk_odd_even: assert property (
    !s_r.mem_mode[vsc_pkg::MM_CHAIN4] && !s_r.mem_mode[vsc_pkg::MM_SEQ]
    |=> (host_plane_en_o & ($past(host_addr_i[0]) ? 4'h5 : 4'hA)) == 4'h0)
    else $error("odd/even plane split wrong");

  chk_reserved_read: assert property (
    io_rd_i && io_data_sel_i && s_r.idx > vsc_pkg::IDX_MEMMODE |=> io_rdata_o == 8'h00)
    else $error("unused index did not read zero");

  chk_reserved_bits: assert property (
    (s_r.clk_mode & ~vsc_pkg::CLK_MASK) == 8'h00
    && (s_r.font_sel & ~vsc_pkg::FONT_MASK) == 8'h00
    && (s_r.mem_mode & ~vsc_pkg::MM_MASK) == 8'h00)
    else $error("reserved register bit set");

endmodule : vsc_sequencer

`default_nettype wire

// >>> vsc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host processor side of the index and data ports
module vsc_host_model (
  input  wire logic       mclk_i,
  output logic            io_wr_o,
  output logic            io_rd_o,
  output logic            io_sel_o,
  output logic [7:0]      io_wdata_o
);
  // Idle bus at time zero
  initial begin
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_sel_o   = 1'b0;
    io_wdata_o = 8'h00;
  end

  // One write strobe held to its sampling edge, then an idle cycle
  task automatic put(input logic sel, input logic [7:0] d);
    io_wr_o    <= 1'b1;
    io_sel_o   <= sel;
    io_wdata_o <= d;
    @(posedge mclk_i);
    io_wr_o    <= 1'b0;
    io_wdata_o <= ~d;  // Released data never shows the stale byte
    @(posedge mclk_i);
  endtask : put

  // One read strobe at the chosen port
  task automatic get(input logic sel);
    io_rd_o  <= 1'b1;
    io_sel_o <= sel;
    @(posedge mclk_i);
    io_rd_o  <= 1'b0;
    @(posedge mclk_i);
  endtask : get
endmodule : vsc_host_model

`default_nettype wire

// >>> vsc_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Self-checking bench for the sequencer control block
module vsc_sequencer_tb;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        io_wr, io_rd, io_sel, rd_seen = 1'b0;
  logic [7:0]  io_wd, rdata, pxwe, bwe, f;
  logic        ovr = 1'b0, ext = 1'b0, wm1 = 1'b0, wide = 1'b0;
  logic [2:0]  wmode = 3'h0, p, s, t;
  logic [7:0]  attr = 8'h00, code = 8'h00;
  logic [4:0]  row = 5'h00;
  logic [1:0]  kind = 2'h0, swidth, fplane, tplane, ew;
  logic [21:0] haddr = 22'h0, hma, ea;
  logic        run, mref, sync, sref, dot, chr, load, dual, inten;
  logic [3:0]  pwe, hpl, ep;
  logic [15:0] faddr;
  logic [31:0] r = 32'h0C89;
  logic [7:0]  exp_q [$];
  int          mismatches = 0, total_checks = 0, n;
  logic [7:0]  rv [5] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  msk [8] = '{8'h00, vsc_pkg::CLK_MASK, vsc_pkg::STD_MASK, vsc_pkg::FONT_MASK,
                           vsc_pkg::MM_MASK, 8'h00, 8'h00, 8'h00};
  logic [7:0]  cm [8] = '{8'h01, 8'h01, 8'h00, 8'h09, 8'h09, 8'h05, 8'h11, 8'h15};
  int          sg [8] = '{0, 1, 1, 0, 1, 2, 2, 2};
  int          ge [8] = '{1, 8, 9, 2, 16, 16, 32, 32};
  logic [7:0]  hm [4] = '{8'h0A, 8'h06, 8'h02, 8'h04};

  // Clock
  always #10 mclk_i = ~mclk_i;

  // Host partner and the block under test
  vsc_host_model u_host (.mclk_i(mclk_i), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_sel_o(io_sel), .io_wdata_o(io_wd));
  vsc_sequencer u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_data_sel_i(io_sel), .io_wdata_i(io_wd), .io_rdata_o(rdata),
    .graphics_ext_refresh_override_i(ovr), .ext_write_en_i(ext), .wm1_ext_i(wm1),
    .graphics_write_mode_i(wmode), .attr_byte_i(attr), .char_code_i(code), .char_row_i(row),
    .wide_font_i(wide), .text_fetch_kind_i(kind), .host_addr_i(haddr), .seq_run_o(run),
    .mem_refresh_en_o(mref), .sync_en_o(sync), .screen_refresh_en_o(sref),
    .dot_clk_en_o(dot), .char_clk_en_o(chr), .shifter_load_o(load), .shift_width_o(swidth),
    .plane_we_o(pwe), .pixel_we_o(pxwe), .blt_pixel_we_o(bwe), .dual_font_o(dual),
    .font_addr_o(faddr), .font_plane_o(fplane), .text_plane_o(tplane), .intensity_o(inten),
    .host_plane_en_o(hpl), .host_mem_addr_o(hma));

  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic pick(input int w);
    return (w == 0) ? dot : (w == 1) ? chr : load;
  endfunction : pick

  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
  endtask : step

  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    u_host.put(1'b0, {3'h0, i});
    u_host.put(1'b1, d);
  endtask : wr

  // Note the expected byte, then strobe the read
  task automatic rd(input logic [4:0] i, input logic [7:0] e);
    u_host.put(1'b0, {3'h0, i});
    exp_q.push_back(e);
    u_host.get(1'b1);
  endtask : rd

  task automatic bad(input logic [31:0] g, input logic [31:0] e);
    mismatches++;
    $display("BAD %0t got %0h exp %0h", $time, g, e);
  endtask : bad

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) bad(g, e);
  endtask : check_val

  task automatic check_rd(input logic [7:0] e);
    total_checks++;
    if (rdata !== e) bad({24'h0, rdata}, {24'h0, e});
  endtask : check_rd

  // Cycles between two pulses of the chosen strobe
  task automatic gap(input int w, output int k);
    for (int i = 0; i < 200 && !pick(w); i++) @(posedge mclk_i);
    @(posedge mclk_i);
    k = 1;
    while (!pick(w) && k < 200) begin
      @(posedge mclk_i);
      k++;
    end
  endtask : gap

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Read monitor: oldest note against the byte after each strobe
  always @(posedge mclk_i) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) bad({24'h0, rdata}, 32'h0);
      else check_rd(exp_q.pop_front());
    end
    rd_seen <= io_rd;
  end

  // Watchdog
  initial begin
    step(20000);
    mismatches++;
    complete_run();
  end

  // ==========================================================
  // Test sequence
  initial begin
    step(12);
    rst_i <= 1'b0;
    step(1);
    foreach (rv[i]) rd(i[4:0], rv[i]);
    u_host.put(1'b0, 8'hF3);
    exp_q.push_back(8'h13);
    u_host.get(1'b0);
    for (int i = 1; i < 8; i++) begin
      r = lfsr(r);
      wr(i[4:0], r[7:0]);
      rd(i[4:0], r[7:0] & msk[i]);
    end
    ext <= 1'b1;
    wr(5'h02, 8'hA7);
    rd(5'h02, 8'hA7);
    $display("registers done");
    wr(5'h03, 8'h3F);
    wr(5'h00, 8'h02);
    check_val({run, mref, sync}, 3'h0);
    rd(5'h03, 8'h00);
    repeat (20) begin
      step(1);
      check_val({dot, chr, load}, 3'h0);
    end
    wr(5'h00, 8'h01);
    check_val({run, mref, sref}, 3'h0);
    wr(5'h00, 8'h03);
    check_val({run, mref, sync}, 3'h7);
    wr(5'h01, 8'h20);
    check_val({sref, sync, mref}, 3'h3);
    wr(5'h01, 8'h00);
    ovr <= 1'b1;
    step(2);
    check_val(sref, 1'b0);
    ovr <= 1'b0;
    step(2);
    check_val(sref, 1'b1);
    $display("reset and refresh done");
    foreach (cm[i]) begin
      wr(5'h01, cm[i]);
      gap(sg[i], n);
      check_val(n, ge[i]);
      ew = cm[i][4] ? vsc_pkg::WIDTH_32 : cm[i][2] ? vsc_pkg::WIDTH_16 : vsc_pkg::WIDTH_8;
      check_val(swidth, ew);
    end
    check_val(swidth, vsc_pkg::WIDTH_32);
    $display("clocking done");
    for (int i = 0; i < 32; i++) begin
      {ext, wm1, wmode} <= i[4:0];
      step(2);
      check_val(pwe, (!i[4] && !i[2]) ? 4'h7 : 4'h0);
      f = (i[4] && ((i[2:0] == 3'h1 && i[3]) || i[2:1] == 2'h2)) ? 8'hA7 : 8'hFF;
      check_val(pxwe, f);
      check_val(bwe, 8'hA7);
    end
    $display("write masks done");
    wr(5'h04, 8'h02);
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      f = (i < 8) ? {2'h0, i[2], i[2], i[1:0], i[1:0]} : {2'h0, r[5:0]};
      wr(5'h03, f);
      {attr, code, row} <= r[28:8];
      step(2);
      p = {f[4], f[1:0]};
      s = {f[5], f[3:2]};
      t = (p != s && attr[3]) ? s : p;
      check_val(dual, p != s);
      check_val(faddr, {t[1:0], t[2], code, row});
      check_val(inten, (p != s) ? 1'b0 : attr[3]);
    end
    for (int i = 0; i < 8; i++) begin
      {wide, kind} <= i[2:0];
      step(2);
      check_val(fplane, i[2] ? 2'h3 : 2'h2);
      check_val(tplane, i[1:0]);
    end
    $display("fonts done");
    foreach (hm[i]) begin
      r = lfsr(r);
      wr(5'h04, hm[i]);
      haddr <= r[21:0];
      step(2);
      ep = (i == 0) ? 4'h1 << r[1:0] : (i == 2) ? (r[0] ? 4'h2 : 4'h5) : 4'h7;
      ea = (i == 0) ? r[21:2] : (i == 2) ? r[21:1] : (i == 3) ? r[15:0] : r[21:0];
      check_val(hpl, ep);
      check_val(hma, ea);
    end
    $display("host paths done");
    complete_run();
  end
endmodule : vsc_sequencer_tb

`default_nettype wire
